// *** avc_cfg.svh ***
`ifndef AVC_CFG_SVH
`define AVC_CFG_SVH

// register byte offsets
`define AVC_OFS_FIXED_REF_CTRL 8'h00
`define AVC_OFS_CONV_CTRL0 8'h04
`define AVC_OFS_CONV_CTRL1 8'h08
`define AVC_OFS_RESULT_HIGH 8'h0C
`define AVC_OFS_RESULT_LOW 8'h10
`define AVC_OFS_IRQ_STATUS 8'h14
`define AVC_OFS_IRQ_MASK 8'h18

// fixed_reference_control fields
`define AVC_FRC_ENABLE_BIT 7
`define AVC_FRC_READY_BIT 6
`define AVC_FRC_CDAC_LSB 2
`define AVC_FRC_ADC_LSB 0

// converter_control_0 fields
`define AVC_CC0_ON_BIT 0
`define AVC_CC0_GO_BIT 1
`define AVC_CC0_CHS_LSB 2

// converter_control_1 fields
`define AVC_CC1_FMT_BIT 7
`define AVC_CC1_CLK_LSB 4
`define AVC_CC1_NREF_BIT 2
`define AVC_CC1_PREF_LSB 0

// interrupt status / mask fields
`define AVC_IRQ_DONE_BIT 0
`define AVC_IRQ_READY_BIT 1

// reset values
`define AVC_RST_BYTE 8'h00
`define AVC_RST_WORD 32'h00000000

// encodings
`define AVC_CLK_RC 2'b11
`define AVC_PREF_FVR4X 2'b11
`define AVC_PREF_FVR2X 2'b10
`define AVC_TRIAL_TOP 10'h200

// timing counts in half periods of the conversion clock
`define AVC_SETTLE_HALVES 5'h03
`define AVC_BIT_HALVES 5'h02
`define AVC_TOP_BIT 4'h9

// reference stabilization in system clocks
`define AVC_REF_STAB_CYCLES 64

`endif

// *** avc_pkg.sv ***
package avc_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {
        AVC_IDLE = 2'b00,
        AVC_SETTLE = 2'b01,
        AVC_BITS = 2'b10
    } avc_state_t;

    // divider exponent for a system clock selection
    function automatic logic [2:0] avc_half_shift(input logic [2:0] sel);
        avc_half_shift = {sel[1:0], sel[2]};
    endfunction : avc_half_shift

endpackage : avc_pkg

// *** avc_tad_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "avc_cfg.svh"

module avc_tad_gen
    import avc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [2:0] clock_select,
    input wire logic rc_tick,
    output logic half_tick
);

    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic next_half_tick;
    logic [5:0] limit;

    // half period tick generator
    always_comb begin
        limit = 6'((7'h01 << avc_half_shift(clock_select)) - 7'h01);
        next_cnt = cnt;
        next_half_tick = 1'b0;
        if (!run) begin
            next_cnt = 6'h00;
        end else if (clock_select[1:0] == `AVC_CLK_RC) begin
            next_cnt = 6'h00;
            next_half_tick = rc_tick;
        end else if (cnt == limit) begin
            next_cnt = 6'h00;
            next_half_tick = 1'b1;
        end else begin
            next_cnt = cnt + 6'h01;
        end
    end

    // divider registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 6'h00;
            half_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            half_tick <= next_half_tick;
        end
    end

endmodule : avc_tad_gen
`default_nettype wire

// *** avc_top.sv ***
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "avc_cfg.svh"

// Function
// - enable bit switches fixed reference
// - ready flag after reference stabilizes
// - reserved reference bits read zero
// - comparator/dac gain field selects level
// - converter gain field selects level
// - ready always one with regulator
// - ten-bit successive approximation into result pair
// - completion interrupt, wakes from sleep
// - channel select drives sample-and-hold
// - positive reference select, no 4x low-voltage
// - negative reference pin or ground
// - three-bit conversion clock divider select
// - conversion lasts eleven and half periods
// - divided clock tracks system clock
// - go starts; done clears, flags, updates
// - format bit left or right justifies
module avc_top
    import avc_pkg::*;
#(
    parameter bit HAS_LDO = 1'b0,
    parameter bit LOW_VOLTAGE = 1'b0,
    parameter int REF_STAB_CYCLES = `AVC_REF_STAB_CYCLES,
    parameter int STAB_W = 16
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wake_request,
    input wire logic sleep_active,
    input wire logic rc_tick,
    input wire logic comparator_high,
    output logic reference_enable,
    output logic [1:0] comparator_dac_gain_select,
    output logic [1:0] converter_gain_select,
    output logic [4:0] channel_select,
    output logic [1:0] positive_reference_select,
    output logic negative_reference_select,
    output logic sample_hold_track,
    output logic [9:0] sar_trial
);

    // register state
    logic reference_ready_flag;
    logic converter_on;
    logic go_done;
    logic result_format_select;
    logic [2:0] conversion_clock_select;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    avc_state_t state;
    logic [4:0] half_cnt;
    logic [3:0] bit_idx;
    logic [STAB_W-1:0] stab_cnt;
    logic half_tick;

    // next values
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic next_wake_request;
    logic next_reference_enable;
    logic [1:0] next_cdac_gain;
    logic [1:0] next_adc_gain;
    logic [4:0] next_channel;
    logic [1:0] next_pref;
    logic next_nref;
    logic next_track;
    logic [9:0] next_trial;
    logic next_ready;
    logic next_converter_on;
    logic next_go_done;
    logic next_format;
    logic [2:0] next_clock_select;
    logic [7:0] next_result_high;
    logic [7:0] next_result_low;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    avc_state_t next_state;
    logic [4:0] next_half_cnt;
    logic [3:0] next_bit_idx;
    logic [STAB_W-1:0] next_stab_cnt;

    // bus strobes
    logic setup;
    logic wr;
    logic [1:0] set_events;
    logic [9:0] new_result;
    logic update_result;

    // conversion clock source
    avc_tad_gen u_tad (
        .clk(clk),
        .nrst(nrst),
        .run(state != AVC_IDLE),
        .clock_select(conversion_clock_select),
        .rc_tick(rc_tick),
        .half_tick(half_tick)
    );

    // address decode
    function automatic logic avc_mapped(input logic [7:0] a);
        case (a)
            `AVC_OFS_FIXED_REF_CTRL, `AVC_OFS_CONV_CTRL0, `AVC_OFS_CONV_CTRL1,
            `AVC_OFS_RESULT_HIGH, `AVC_OFS_RESULT_LOW, `AVC_OFS_IRQ_STATUS,
            `AVC_OFS_IRQ_MASK: avc_mapped = 1'b1;
            default: avc_mapped = 1'b0;
        endcase
    endfunction : avc_mapped

    // terminated result: undecided bits copy the last decided bit
    function automatic logic [9:0] avc_partial(input logic [9:0] acc, input logic [3:0] idx, input logic any);
        logic [9:0] r;
        r = 10'h000;
        for (int j = 0; j < 10; j++) begin
            if (!any) begin
                r[j] = 1'b0;
            end else if (j > int'(idx)) begin
                r[j] = acc[j];
            end else begin
                r[j] = acc[int'(idx) + 1];
            end
        end
        avc_partial = r;
    endfunction : avc_partial

    // apb slave: one wait state, data and error captured at setup
    always_comb begin
        setup = psel && !penable;
        wr = psel && penable && pready && pwrite;
        next_pready = setup;
        next_pslverr = setup && !avc_mapped(paddr);
        next_prdata = prdata;
        if (setup) begin
            next_prdata = `AVC_RST_WORD;
            case (paddr)
                `AVC_OFS_FIXED_REF_CTRL: next_prdata[7:0] = {reference_enable, reference_ready_flag, 2'b00,
                    comparator_dac_gain_select, converter_gain_select};
                `AVC_OFS_CONV_CTRL0: next_prdata[7:0] = {1'b0, channel_select, go_done, converter_on};
                `AVC_OFS_CONV_CTRL1: next_prdata[7:0] = {result_format_select, conversion_clock_select, 1'b0,
                    negative_reference_select, positive_reference_select};
                `AVC_OFS_RESULT_HIGH: next_prdata[7:0] = result_high;
                `AVC_OFS_RESULT_LOW: next_prdata[7:0] = result_low;
                `AVC_OFS_IRQ_STATUS: next_prdata[1:0] = irq_status;
                `AVC_OFS_IRQ_MASK: next_prdata[1:0] = irq_mask;
                default: next_prdata = `AVC_RST_WORD;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= `AVC_RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // configuration, reference, sequencer and interrupts
    always_comb begin
        next_reference_enable = reference_enable;
        next_cdac_gain = comparator_dac_gain_select;
        next_adc_gain = converter_gain_select;
        next_channel = channel_select;
        next_pref = positive_reference_select;
        next_nref = negative_reference_select;
        next_converter_on = converter_on;
        next_go_done = go_done;
        next_format = result_format_select;
        next_clock_select = conversion_clock_select;
        next_result_high = result_high;
        next_result_low = result_low;
        next_irq_mask = irq_mask;
        next_state = state;
        next_half_cnt = half_cnt;
        next_bit_idx = bit_idx;
        next_trial = sar_trial;
        next_stab_cnt = stab_cnt;
        next_ready = reference_ready_flag;
        set_events = 2'b00;
        new_result = 10'h000;
        update_result = 1'b0;

        // register writes
        if (wr) begin
            case (paddr)
                `AVC_OFS_FIXED_REF_CTRL: begin
                    next_reference_enable = pwdata[`AVC_FRC_ENABLE_BIT];
                    next_cdac_gain = pwdata[`AVC_FRC_CDAC_LSB +: 2];
                    next_adc_gain = pwdata[`AVC_FRC_ADC_LSB +: 2];
                end
                `AVC_OFS_CONV_CTRL0: begin
                    next_converter_on = pwdata[`AVC_CC0_ON_BIT];
                    next_channel = pwdata[`AVC_CC0_CHS_LSB +: 5];
                end
                `AVC_OFS_CONV_CTRL1: begin
                    next_format = pwdata[`AVC_CC1_FMT_BIT];
                    next_clock_select = pwdata[`AVC_CC1_CLK_LSB +: 3];
                    next_nref = pwdata[`AVC_CC1_NREF_BIT];
                    if (LOW_VOLTAGE && pwdata[`AVC_CC1_PREF_LSB +: 2] == `AVC_PREF_FVR4X) begin
                        next_pref = `AVC_PREF_FVR2X;
                    end else begin
                        next_pref = pwdata[`AVC_CC1_PREF_LSB +: 2];
                    end
                end
                `AVC_OFS_IRQ_MASK: next_irq_mask = pwdata[1:0];
                default: next_irq_mask = irq_mask;
            endcase
        end

        // go starts conversion, clearing go aborts it; other control writes keep the half ticks
        if (wr && paddr == `AVC_OFS_CONV_CTRL0 && pwdata[`AVC_CC0_GO_BIT] && next_converter_on
                && state == AVC_IDLE) begin
            next_go_done = 1'b1;
            next_state = AVC_SETTLE;
            next_half_cnt = 5'h00;
            next_trial = 10'h000;
        end else if (wr && paddr == `AVC_OFS_CONV_CTRL0 && !pwdata[`AVC_CC0_GO_BIT] && state != AVC_IDLE) begin
            // software abort keeps the partial result
            next_go_done = 1'b0;
            next_state = AVC_IDLE;
            update_result = 1'b1;
            new_result = avc_partial(sar_trial, bit_idx, state == AVC_BITS && bit_idx != `AVC_TOP_BIT);
        end else if (state != AVC_IDLE && (!converter_on ||
                (sleep_active && conversion_clock_select[1:0] != `AVC_CLK_RC))) begin
            next_go_done = 1'b0;
            next_state = AVC_IDLE;
        end else if (half_tick) begin
            // one and a half periods settle, two halves per bit
            case (state)
                AVC_SETTLE: begin
                    if (half_cnt == `AVC_SETTLE_HALVES - 5'h01) begin
                        next_state = AVC_BITS;
                        next_half_cnt = 5'h00;
                        next_bit_idx = `AVC_TOP_BIT;
                        next_trial = `AVC_TRIAL_TOP;
                    end else begin
                        next_half_cnt = half_cnt + 5'h01;
                    end
                end
                AVC_BITS: begin
                    if (half_cnt == `AVC_BIT_HALVES - 5'h01) begin
                        next_half_cnt = 5'h00;
                        next_trial[bit_idx] = comparator_high;
                        if (bit_idx == 4'h0) begin
                            next_state = AVC_IDLE;
                            next_go_done = 1'b0;
                            set_events[`AVC_IRQ_DONE_BIT] = 1'b1;
                            update_result = 1'b1;
                            new_result = next_trial;
                        end else begin
                            next_bit_idx = bit_idx - 4'h1;
                            next_trial[bit_idx - 4'h1] = 1'b1;
                        end
                    end else begin
                        next_half_cnt = half_cnt + 5'h01;
                    end
                end
                default: next_state = AVC_IDLE;
            endcase
        end

        if (update_result) begin
            if (next_format) begin
                next_result_high = new_result[9:2];
                next_result_low = {new_result[1:0], 6'h00};
            end else begin
                next_result_high = {6'h00, new_result[9:8]};
                next_result_low = new_result[7:0];
            end
        end

        if (HAS_LDO) begin
            next_ready = 1'b1;
            next_stab_cnt = '0;
        end else if (!next_reference_enable) begin
            next_ready = 1'b0;
            next_stab_cnt = '0;
        end else if (!reference_ready_flag) begin
            if (stab_cnt == STAB_W'(REF_STAB_CYCLES - 1)) begin
                next_ready = 1'b1;
            end else begin
                next_stab_cnt = stab_cnt + 1'b1;
            end
        end
        if (next_ready && !reference_ready_flag && !HAS_LDO) begin
            set_events[`AVC_IRQ_READY_BIT] = 1'b1;
        end

        // sticky flags, a new event beats write-one clear
        next_irq_status = irq_status;
        if (wr && paddr == `AVC_OFS_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[1:0];
        end
        next_irq_status = next_irq_status | set_events;

        next_irq = |(next_irq_status & next_irq_mask);
        next_wake_request = sleep_active && next_irq_status[`AVC_IRQ_DONE_BIT] && next_irq_mask[`AVC_IRQ_DONE_BIT];
        next_track = next_converter_on && next_state == AVC_IDLE;
    end

    // core registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reference_enable <= 1'b0;
            comparator_dac_gain_select <= 2'b00;
            converter_gain_select <= 2'b00;
            channel_select <= 5'h00;
            positive_reference_select <= 2'b00;
            negative_reference_select <= 1'b0;
            converter_on <= 1'b0;
            go_done <= 1'b0;
            result_format_select <= 1'b0;
            conversion_clock_select <= 3'h0;
            result_high <= `AVC_RST_BYTE;
            result_low <= `AVC_RST_BYTE;
            irq_status <= 2'b00;
            irq_mask <= 2'b00;
            state <= AVC_IDLE;
            half_cnt <= 5'h00;
            bit_idx <= 4'h0;
            sar_trial <= 10'h000;
            stab_cnt <= '0;
            reference_ready_flag <= 1'b0;
            irq <= 1'b0;
            wake_request <= 1'b0;
            sample_hold_track <= 1'b0;
        end else begin
            reference_enable <= next_reference_enable;
            comparator_dac_gain_select <= next_cdac_gain;
            converter_gain_select <= next_adc_gain;
            channel_select <= next_channel;
            positive_reference_select <= next_pref;
            negative_reference_select <= next_nref;
            converter_on <= next_converter_on;
            go_done <= next_go_done;
            result_format_select <= next_format;
            conversion_clock_select <= next_clock_select;
            result_high <= next_result_high;
            result_low <= next_result_low;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            state <= next_state;
            half_cnt <= next_half_cnt;
            bit_idx <= next_bit_idx;
            sar_trial <= next_trial;
            stab_cnt <= next_stab_cnt;
            reference_ready_flag <= next_ready;
            irq <= next_irq;
            wake_request <= next_wake_request;
            sample_hold_track <= next_track;
        end
    end

endmodule : avc_top
`default_nettype wire

// *** avc_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module avc_properties #(
    parameter bit LOW_VOLTAGE = 1'b0
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_request,
    input wire logic sleep_active,
    input wire logic reference_enable,
    input wire logic [1:0] comparator_dac_gain_select,
    input wire logic [1:0] converter_gain_select,
    input wire logic [4:0] channel_select,
    input wire logic [1:0] positive_reference_select,
    input wire logic negative_reference_select
);
    logic wr_done;
    // completed write strobe
    assign wr_done = psel & penable & pready & pwrite;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // one wait state, answer only in access
    a_one_wait: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_unmapped: assert property (psel && !penable && paddr == 8'h1C |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_enable_write: assert property (wr_done && paddr == 8'h00 |=> reference_enable == $past(pwdata[7])
        && comparator_dac_gain_select == $past(pwdata[3:2]) && converter_gain_select == $past(pwdata[1:0]))
        else $error("reference fields not taken");
    a_enable_hold: assert property (!(wr_done && paddr == 8'h00) |=> $stable(reference_enable)
        && $stable(comparator_dac_gain_select) && $stable(converter_gain_select))
        else $error("reference fields moved");
    a_chan_write: assert property (wr_done && paddr == 8'h04 |=> channel_select == $past(pwdata[6:2]))
        else $error("channel not taken");
    a_ref_select: assert property (wr_done && paddr == 8'h08 |=> negative_reference_select == $past(pwdata[2])
        && positive_reference_select == ((LOW_VOLTAGE && $past(pwdata[1:0]) == 2'b11) ? 2'b10 : $past(pwdata[1:0])))
        else $error("reference select not taken");
    a_wake_sleep: assert property (wake_request |-> $past(sleep_active))
        else $error("wake outside sleep");
endmodule : avc_properties
bind avc_top avc_properties #(.LOW_VOLTAGE(LOW_VOLTAGE)) u_avc_properties (.clk(clk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_request(wake_request), .sleep_active(sleep_active), .reference_enable(reference_enable),
    .comparator_dac_gain_select(comparator_dac_gain_select), .converter_gain_select(converter_gain_select),
    .channel_select(channel_select), .positive_reference_select(positive_reference_select),
    .negative_reference_select(negative_reference_select));
`default_nettype wire

// *** avc_analog_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module avc_analog_model #(
    parameter int RC_HALF = 3
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [9:0] sar_trial,
    input wire logic [9:0] level,
    output logic comparator_high,
    output logic rc_tick
);
    int cnt;
    assign comparator_high = (level >= sar_trial);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            rc_tick <= 1'b0;
        end else begin
            cnt <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
            rc_tick <= (cnt == RC_HALF - 1);
        end
    end
endmodule : avc_analog_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int STAB = 4;
    localparam int ACQ = 8;
    logic clk, nrst, psel, penable, pwrite, sleep_active, pslverr, pready, irq, wake_request, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rc_tick, comparator_high, reference_enable, negative_reference_select, sample_hold_track;
    logic [1:0] comparator_dac_gain_select, converter_gain_select, positive_reference_select;
    logic [4:0] channel_select;
    logic [9:0] sar_trial, level;
    int error_cnt, checked;
    avc_top #(.REF_STAB_CYCLES(STAB)) u_avc_top (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .wake_request(wake_request), .sleep_active(sleep_active), .rc_tick(rc_tick),
        .comparator_high(comparator_high), .reference_enable(reference_enable),
        .comparator_dac_gain_select(comparator_dac_gain_select), .converter_gain_select(converter_gain_select),
        .channel_select(channel_select), .positive_reference_select(positive_reference_select),
        .negative_reference_select(negative_reference_select), .sample_hold_track(sample_hold_track),
        .sar_trial(sar_trial));
    avc_analog_model u_avc_analog_model (.clk(clk), .nrst(nrst), .sar_trial(sar_trial), .level(level),
        .comparator_high(comparator_high), .rc_tick(rc_tick));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // turn on, wait acquisition, start, wait for tracking again
    task automatic conv(input logic [7:0] c1, input logic [4:0] ch, input logic [9:0] lv, output int cyc);
        level <= lv;
        apb(1'b1, 8'h08, {24'h0, c1});
        apb(1'b1, 8'h04, {25'h0, ch, 2'b01});
        repeat (ACQ) @(posedge clk);
        apb(1'b1, 8'h04, {25'h0, ch, 2'b11});
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (sample_hold_track !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) error_cnt++;
    endtask : conv
    // result pair readback
    task automatic res(input logic [7:0] hi, input logic [7:0] lo);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, {24'h0, hi});
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, {24'h0, lo});
    endtask : res
    // reset values and unmapped hole
    task automatic t_reset();
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk(32'(er), 32'h1);
    endtask : t_reset
    // reference enable, ready, reserved, gains
    task automatic t_reference();
        apb(1'b1, 8'h00, 32'h000000B6);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00000086);
        chk(32'({reference_enable, comparator_dac_gain_select, converter_gain_select}), 32'h16);
        repeat (STAB + 2) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h000000C6);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b1, 8'h14, 32'h2);
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, 8'h00, 32'(8'h80 | (g << 2) | (3 - g)));
            apb(1'b0, 8'h00, 32'h0);
            chk(32'({comparator_dac_gain_select, converter_gain_select}), 32'((g << 2) | (3 - g)));
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        chk(32'(reference_enable), 32'h0);
    endtask : t_reference
    // clock, reference and channel selections
    task automatic t_config();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h08, 32'((i << 4) | ((i & 1) << 2) | (i & 3)));
            apb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'((i << 4) | ((i & 1) << 2) | (i & 3)));
            chk(32'({negative_reference_select, positive_reference_select}), 32'(((i & 1) << 2) | (i & 3)));
        end
        for (int c = 0; c < 14; c++) begin
            apb(1'b1, 8'h04, 32'(c << 2));
            apb(1'b0, 8'h04, 32'h0);
            chk(32'(channel_select), 32'(c));
        end
    endtask : t_config
    // conversions with both formats and two dividers
    task automatic t_convert();
        int cyc;
        apb(1'b1, 8'h18, 32'h1);
        conv(8'h00, 5'd3, 10'h2B5, cyc);
        chk(32'(cyc >= 23 && cyc <= 27), 32'h1);
        chk(32'(sar_trial), 32'h2B5);
        res(8'h02, 8'hB5);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0D);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h1, 32'h0);
        chk(32'(irq), 32'h0);
        conv(8'hC0, 5'd13, 10'h1CE, cyc);
        chk(32'(cyc >= 46 && cyc <= 50), 32'h1);
        res(8'h73, 8'h80);
        apb(1'b1, 8'h14, 32'h1);
    endtask : t_convert
    // rc clocked conversion in sleep, masked then unmasked
    task automatic t_sleep();
        int cyc;
        apb(1'b1, 8'h18, 32'h0);
        sleep_active <= 1'b1;
        conv(8'h30, 5'd12, 10'h3FF, cyc);
        res(8'h03, 8'hFF);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'({irq, wake_request}), 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'({irq, wake_request}), 32'h3);
        apb(1'b1, 8'h14, 32'h1);
        conv(8'h00, 5'd12, 10'h155, cyc);
        chk(32'(cyc <= 3), 32'h1);
        res(8'h03, 8'hFF);
        chk(32'(irq), 32'h0);
        sleep_active <= 1'b0;
    endtask : t_sleep
    // verdict and end of run
    task automatic complete_run();
        $display("mismatches=%0d comparisons=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep_active = 1'b0;
        level = 10'h000;
        error_cnt = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_reference();
        t_config();
        t_convert();
        t_sleep();
        complete_run();
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
